// >>> common/bdm_pkg.sv
// Constants, encodings and timing for the supply drop detector control block.
// Assumes a 250 MHz system clock and an APB register port with 32-bit data.
package bdm_pkg;

  // ==========================================================================
  // Register indices and byte addresses (byte address is four times the index)
  localparam int           BDM_ADDR_W         = 12;
  localparam logic [7:0]   BDM_IDX_MODE_CTRL  = 8'h00;
  localparam logic [7:0]   BDM_IDX_LEVEL_SEL  = 8'h01;
  localparam logic [7:0]   BDM_IDX_WARN_LEVEL = 8'h08;
  localparam logic [7:0]   BDM_IDX_IRQ_CTRL   = 8'h09;
  localparam logic [7:0]   BDM_IDX_IRQ_FLAG   = 8'h0a;
  localparam logic [7:0]   BDM_IDX_STATUS     = 8'h0b;
  localparam logic [11:0]  BDM_ADDR_MODE_CTRL  = {2'h0, BDM_IDX_MODE_CTRL, 2'h0};
  localparam logic [11:0]  BDM_ADDR_LEVEL_SEL  = {2'h0, BDM_IDX_LEVEL_SEL, 2'h0};
  localparam logic [11:0]  BDM_ADDR_WARN_LEVEL = {2'h0, BDM_IDX_WARN_LEVEL, 2'h0};
  localparam logic [11:0]  BDM_ADDR_IRQ_CTRL   = {2'h0, BDM_IDX_IRQ_CTRL, 2'h0};
  localparam logic [11:0]  BDM_ADDR_IRQ_FLAG   = {2'h0, BDM_IDX_IRQ_FLAG, 2'h0};
  localparam logic [11:0]  BDM_ADDR_STATUS     = {2'h0, BDM_IDX_STATUS, 2'h0};

  // ==========================================================================
  // Field positions
  localparam int BDM_SAMPLE_RATE_BIT = 4;
  localparam int BDM_ACTIVE_LSB      = 2;
  localparam int BDM_SLEEP_LSB       = 0;
  localparam int BDM_TRIGGER_LSB     = 1;
  localparam int BDM_IRQ_EN_BIT      = 0;
  localparam int BDM_FLAG_BIT        = 0;
  localparam int BDM_STATUS_BIT      = 0;

  // ==========================================================================
  // Encodings and reset values
  typedef enum logic [1:0] {
    BDM_MODE_OFF       = 2'h0,
    BDM_MODE_CONT      = 2'h1,
    BDM_MODE_SAMPLED   = 2'h2,
    BDM_MODE_CONT_HOLD = 2'h3
  } bdm_mode_t;

  localparam logic [1:0] BDM_TRIG_BELOW = 2'h0;
  localparam logic [1:0] BDM_TRIG_ABOVE = 2'h1;
  localparam logic [1:0] BDM_TRIG_CROSS = 2'h2;

  localparam logic [1:0] BDM_MARGIN_5PCT  = 2'h0;
  localparam logic [1:0] BDM_MARGIN_15PCT = 2'h1;
  localparam logic [1:0] BDM_MARGIN_25PCT = 2'h2;

  localparam logic [2:0] BDM_THRESHOLD_LOW_CODE  = 3'h2;
  localparam logic [2:0] BDM_THRESHOLD_HIGH_CODE = 3'h7;

  localparam logic [1:0] BDM_MARGIN_RST  = BDM_MARGIN_5PCT;
  localparam logic [1:0] BDM_TRIGGER_RST = BDM_TRIG_BELOW;

  // Power state, Gray coded along run -> sleep -> wake hold
  typedef enum logic [1:0] {
    BDM_ST_RUN   = 2'b00,
    BDM_ST_SLEEP = 2'b01,
    BDM_ST_WAKE  = 2'b11
  } bdm_state_t;

  // ==========================================================================
  // Timing
  localparam int BDM_CLK_PERIOD_NS     = 4;
  localparam int BDM_FAST_PERIOD_US    = 1000;
  localparam int BDM_SLOW_PERIOD_US    = 8000;
  localparam int BDM_FAST_PERIOD_CYC   = BDM_FAST_PERIOD_US * 1000 / BDM_CLK_PERIOD_NS;
  localparam int BDM_SLOW_PERIOD_CYC   = BDM_SLOW_PERIOD_US * 1000 / BDM_CLK_PERIOD_NS;
  localparam logic [2:0] BDM_UNLOCK_WINDOW_CYC = 3'h4;

endpackage : bdm_pkg

// >>> design/bdm_sample_timer.sv
// Sample strobe generator for sampled detector operation.
// Assumes run and slow are registered levels in the sys_clk domain.
`timescale 1ns/1ns
`default_nettype none
module bdm_sample_timer
  import bdm_pkg::*;
#(
  parameter int FAST_CYCLES = BDM_FAST_PERIOD_CYC,
  parameter int SLOW_CYCLES = BDM_SLOW_PERIOD_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic run,
  input  wire logic slow,
  output var  logic tick
);

  localparam int CW = $clog2(SLOW_CYCLES + 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [CW-1:0] reload;
  logic          tick_reg;
  logic          at_zero;

  // ==========================================================================
  // Period select and down counter
  assign reload   = slow ? CW'(SLOW_CYCLES - 1) : CW'(FAST_CYCLES - 1);
  assign at_zero  = (cnt_reg == '0);
  assign cnt_next = !run ? '0 : (at_zero ? reload : cnt_reg - CW'(1));
  assign tick     = tick_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= run & at_zero;
    end
  end

  reload_len_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (run && at_zero && $past(run)) |=> (cnt_reg == $past(reload)))
    else $error("sample period reload value wrong");

endmodule : bdm_sample_timer
`default_nettype wire

// >>> design/bdm_control.sv
// Control and status for the supply drop detector and its early warning monitor.
// Assumes fuse values are stable at reset release, all inputs synchronous to sys_clk.
`timescale 1ns/1ns
`default_nettype none
module bdm_control
  import bdm_pkg::*;
#(
  parameter int FAST_CYCLES = BDM_FAST_PERIOD_CYC,
  parameter int SLOW_CYCLES = BDM_SLOW_PERIOD_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [BDM_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire logic                  fuse_sample_rate_select,
  input  wire logic [1:0]            fuse_active_mode,
  input  wire logic [1:0]            fuse_sleep_mode,
  input  wire logic [2:0]            fuse_threshold_code,
  input  wire logic                  config_change_unlock,
  input  wire logic                  sleep_request,
  input  wire logic                  detector_ready,
  input  wire logic                  supply_below_warning,
  output var  logic                  supply_drop_detector_enable,
  output var  logic                  supply_drop_detector_sampled,
  output var  logic                  sample_strobe,
  output var  logic [2:0]            threshold_code,
  output var  logic [1:0]            warning_margin_select,
  output var  logic                  early_warning_monitor_enable,
  output var  logic                  continuous_hold_on_wake,
  output var  logic                  warning_irq
);

  // ==========================================================================
  // Declarations
  logic        fuse_loaded_reg;
  logic        sample_rate_select_reg;
  bdm_mode_t   active_mode_reg;
  logic [1:0]  sleep_mode_reg;
  logic [1:0]  sleep_mode_next;
  logic [2:0]  threshold_code_reg;
  logic [1:0]  warning_margin_select_reg;
  logic [1:0]  warning_trigger_select_reg;
  logic        warning_irq_enable_reg;
  logic        warning_irq_flag_reg;
  logic        warning_irq_flag_next;
  logic        below_warning_status_reg;
  logic        below_warning_status_next;
  logic [2:0]  unlock_cnt_reg;
  logic [2:0]  unlock_cnt_next;
  bdm_state_t  state_reg;
  bdm_state_t  state_next;
  logic        hold_reg;
  logic        det_en_reg;
  logic        det_sampled_reg;
  logic        monitor_en_reg;
  logic        irq_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        tick;

  // ==========================================================================
  // APB decode
  wire setup      = psel & ~penable;
  wire access     = psel & penable & pready_reg;
  wire wr_access  = access & pwrite;
  wire hit_mode   = (paddr == BDM_ADDR_MODE_CTRL);
  wire hit_level  = (paddr == BDM_ADDR_LEVEL_SEL);
  wire hit_warn   = (paddr == BDM_ADDR_WARN_LEVEL);
  wire hit_ictrl  = (paddr == BDM_ADDR_IRQ_CTRL);
  wire hit_flag   = (paddr == BDM_ADDR_IRQ_FLAG);
  wire hit_status = (paddr == BDM_ADDR_STATUS);
  wire hit_any    = hit_mode | hit_level | hit_warn | hit_ictrl | hit_flag | hit_status;

  wire [7:0] rd_mode   = {3'h0, sample_rate_select_reg, active_mode_reg, sleep_mode_reg};
  wire [7:0] rd_level  = {5'h00, threshold_code_reg};
  wire [7:0] rd_warn   = {6'h00, warning_margin_select_reg};
  wire [7:0] rd_ictrl  = {5'h00, warning_trigger_select_reg, warning_irq_enable_reg};
  wire [7:0] rd_flag   = {7'h00, warning_irq_flag_reg};
  wire [7:0] rd_status = {7'h00, below_warning_status_reg};

  logic [7:0] rd_byte;
  always_comb begin
    if (hit_mode) begin
      rd_byte = rd_mode;
    end else if (hit_level) begin
      rd_byte = rd_level;
    end else if (hit_warn) begin
      rd_byte = rd_warn;
    end else if (hit_ictrl) begin
      rd_byte = rd_ictrl;
    end else if (hit_flag) begin
      rd_byte = rd_flag;
    end else if (hit_status) begin
      rd_byte = rd_status;
    end else begin
      rd_byte = 8'h00;
    end
  end

  wire wr_mode  = wr_access & hit_mode;
  wire wr_warn  = wr_access & hit_warn;
  wire wr_ictrl = wr_access & hit_ictrl;
  wire wr_flag  = wr_access & hit_flag;

  // ==========================================================================
  // Protected sleep field: key opens a short window, one write closes it
  wire unlocked = (unlock_cnt_reg != 3'h0);
  assign unlock_cnt_next = config_change_unlock ? BDM_UNLOCK_WINDOW_CYC :
                           (wr_mode ? 3'h0 : (unlocked ? unlock_cnt_reg - 3'h1 : 3'h0));
  assign sleep_mode_next = (wr_mode && unlocked) ?
                           pwdata[BDM_SLEEP_LSB +: 2] : sleep_mode_reg;

  // ==========================================================================
  // Power state: sleep entry and wake with optional execution hold
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BDM_ST_RUN: begin
        if (sleep_request) begin
          state_next = BDM_ST_SLEEP;
        end
      end
      BDM_ST_SLEEP: begin
        if (!sleep_request) begin
          state_next = (active_mode_reg == BDM_MODE_CONT_HOLD) ? BDM_ST_WAKE : BDM_ST_RUN;
        end
      end
      BDM_ST_WAKE: begin
        if (sleep_request) begin
          state_next = BDM_ST_SLEEP;
        end else if (detector_ready) begin
          state_next = BDM_ST_RUN;
        end
      end
      default: begin
        state_next = BDM_ST_RUN;
      end
    endcase
  end

  // Sleep field governs while asleep, active field otherwise; reserved sleep code is off
  wire       asleep     = (state_next == BDM_ST_SLEEP);
  wire [1:0] eff_mode   = asleep ? sleep_mode_next : active_mode_reg;
  wire       eff_en     = fuse_loaded_reg && (eff_mode != BDM_MODE_OFF) &&
                          !(asleep && (eff_mode == BDM_MODE_CONT_HOLD));
  wire       eff_sample = eff_en && (eff_mode == BDM_MODE_SAMPLED);

  // ==========================================================================
  // Early warning monitor evaluation and trigger select
  wire eval      = monitor_en_reg && (!det_sampled_reg || tick);
  wire evt_below = eval & supply_below_warning & ~below_warning_status_reg;
  wire evt_above = eval & ~supply_below_warning & below_warning_status_reg;
  wire trig_hit  = ((warning_trigger_select_reg == BDM_TRIG_BELOW) & evt_below) |
                   ((warning_trigger_select_reg == BDM_TRIG_ABOVE) & evt_above) |
                   ((warning_trigger_select_reg == BDM_TRIG_CROSS) & (evt_below | evt_above));

  assign below_warning_status_next = eval ? supply_below_warning : below_warning_status_reg;
  assign warning_irq_flag_next = trig_hit |
         (warning_irq_flag_reg & ~(wr_flag & pwdata[BDM_FLAG_BIT]));

  // ==========================================================================
  // Fuse load after reset release
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fuse_loaded_reg        <= 1'b0;
      sample_rate_select_reg <= 1'b0;
      active_mode_reg        <= BDM_MODE_OFF;
      threshold_code_reg     <= 3'h0;
    end else if (!fuse_loaded_reg) begin
      fuse_loaded_reg        <= 1'b1;
      sample_rate_select_reg <= fuse_sample_rate_select;
      active_mode_reg        <= bdm_mode_t'(fuse_active_mode);
      threshold_code_reg     <= fuse_threshold_code;
    end
  end

  // ==========================================================================
  // Software registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sleep_mode_reg             <= 2'h0;
      unlock_cnt_reg             <= 3'h0;
      warning_margin_select_reg  <= BDM_MARGIN_RST;
      warning_trigger_select_reg <= BDM_TRIGGER_RST;
      warning_irq_enable_reg     <= 1'b0;
      warning_irq_flag_reg       <= 1'b0;
      below_warning_status_reg   <= 1'b0;
    end else begin
      sleep_mode_reg             <= fuse_loaded_reg ? sleep_mode_next : fuse_sleep_mode;
      unlock_cnt_reg             <= unlock_cnt_next;
      if (wr_warn) begin
        warning_margin_select_reg <= pwdata[1:0];
      end
      if (wr_ictrl) begin
        warning_trigger_select_reg <= pwdata[BDM_TRIGGER_LSB +: 2];
        warning_irq_enable_reg     <= pwdata[BDM_IRQ_EN_BIT];
      end
      warning_irq_flag_reg       <= warning_irq_flag_next;
      below_warning_status_reg   <= below_warning_status_next;
    end
  end

  // ==========================================================================
  // Detector control outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg       <= BDM_ST_RUN;
      hold_reg        <= 1'b0;
      det_en_reg      <= 1'b0;
      det_sampled_reg <= 1'b0;
      monitor_en_reg  <= 1'b0;
      irq_reg         <= 1'b0;
    end else begin
      state_reg       <= state_next;
      hold_reg        <= (state_next == BDM_ST_WAKE);
      det_en_reg      <= eff_en;
      det_sampled_reg <= eff_sample;
      monitor_en_reg  <= eff_en & warning_irq_enable_reg;
      irq_reg         <= warning_irq_flag_reg & warning_irq_enable_reg;
    end
  end

  // ==========================================================================
  // APB answer: ready in the first access cycle, error on unmapped address
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~hit_any;
      if (setup) begin
        prdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  bdm_sample_timer #(
    .FAST_CYCLES (FAST_CYCLES),
    .SLOW_CYCLES (SLOW_CYCLES)
  ) u_timer (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .run     (det_sampled_reg),
    .slow    (sample_rate_select_reg),
    .tick    (tick)
  );

  assign prdata                       = prdata_reg;
  assign pready                       = pready_reg;
  assign pslverr                      = pslverr_reg;
  assign supply_drop_detector_enable  = det_en_reg;
  assign supply_drop_detector_sampled = det_sampled_reg;
  assign sample_strobe                = tick;
  assign threshold_code               = threshold_code_reg;
  assign warning_margin_select        = warning_margin_select_reg;
  assign early_warning_monitor_enable = monitor_en_reg;
  assign continuous_hold_on_wake      = hold_reg;
  assign warning_irq                  = irq_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence wake_hold_s;
    (state_reg == BDM_ST_SLEEP) && !sleep_request && (active_mode_reg == BDM_MODE_CONT_HOLD);
  endsequence

  sleep_lock_a : assert property ((wr_mode && !unlocked && fuse_loaded_reg)
    |=> $stable(sleep_mode_reg))
    else $error("sleep field changed without unlock");

  sleep_write_a : assert property ((wr_mode && unlocked && fuse_loaded_reg)
    |=> (sleep_mode_reg == $past(pwdata[1:0])))
    else $error("unlocked sleep field write lost");

  active_ro_a : assert property ($past(fuse_loaded_reg) |-> $stable(active_mode_reg))
    else $error("active mode field changed after load");

  mode_follow_a : assert property ((state_reg == BDM_ST_SLEEP) && $stable(state_reg)
    && (sleep_mode_reg == BDM_MODE_OFF) |-> !det_en_reg)
    else $error("detector on in sleep with sleep field off");

  wake_hold_a : assert property (wake_hold_s ##1 !detector_ready && !sleep_request
    |-> continuous_hold_on_wake)
    else $error("execution hold missing at wake");

  monitor_off_a : assert property (!det_en_reg |-> !monitor_en_reg ##1
    $stable(below_warning_status_reg))
    else $error("monitor active while detector off");

  flag_set_a : assert property (trig_hit |=> warning_irq_flag_reg)
    else $error("trigger did not set warning flag");

  flag_clear_a : assert property ((wr_flag && pwdata[0] && !trig_hit)
    |=> !warning_irq_flag_reg)
    else $error("write one did not clear warning flag");

  irq_level_a : assert property ((warning_irq_flag_reg && warning_irq_enable_reg)
    |=> warning_irq ##0 $past(warning_irq_flag_reg))
    else $error("interrupt not asserted with flag and enable");

  trig_below_a : assert property ((warning_trigger_select_reg == BDM_TRIG_BELOW)
    && evt_above && !warning_irq_flag_reg && !wr_flag |=> !warning_irq_flag_reg)
    else $error("rising event set flag in below mode");

endmodule : bdm_control
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the supply drop detector control block.
// Assumes pready answers each APB access and the bench drives fuses and power inputs.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import bdm_pkg::*;
  // ==========================================================================
  // Signals and design
  logic        sys_clk, rstn, psel, penable, pwrite, unl, slp, rdy, blw;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic        pready, pslverr, f_rate, det_en, det_smp, strobe, mon_en, hold, irq;
  logic [1:0]  f_act, f_slp, margin;
  logic [2:0]  f_thr, thr;
  logic [32:0] exq[$];
  int          fails, num_checks, cyc;

  bdm_control #(.FAST_CYCLES(8), .SLOW_CYCLES(64)) i_bdm_control (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fuse_sample_rate_select(f_rate), .fuse_active_mode(f_act), .fuse_sleep_mode(f_slp),
    .fuse_threshold_code(f_thr), .config_change_unlock(unl), .sleep_request(slp),
    .detector_ready(rdy), .supply_below_warning(blw), .supply_drop_detector_enable(det_en),
    .supply_drop_detector_sampled(det_smp), .sample_strobe(strobe), .threshold_code(thr),
    .warning_margin_select(margin), .early_warning_monitor_enable(mon_en),
    .continuous_hold_on_wake(hold), .warning_irq(irq));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) exq.push_back(exp);
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [7:0] b);
    apb(1'b0, a, 32'h0, {25'h0, b});
  endtask : rd

  task automatic unlock_wr(input logic [31:0] d, input int gap);
    @(posedge sys_clk);
    unl <= 1'b1;
    @(posedge sys_clk);
    unl <= 1'b0;
    repeat (gap) @(posedge sys_clk);
    apb(1'b1, BDM_ADDR_MODE_CTRL, d, 33'h0);
  endtask : unlock_wr

  // ==========================================================================
  // Read checker and timeout
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0)
      check("read", {pslverr, prdata}, exq.pop_front());
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [5:0]  ef;
    int          n;
    {rstn, psel, penable, pwrite, unl, slp, rdy, blw} = 8'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    seed = 32'd60052;
    r = xs();
    f_rate = r[0];
    f_slp = r[2:1];
    f_thr = r[5:3];
    f_act = BDM_MODE_CONT;
    ef = 6'b111001;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd(BDM_ADDR_MODE_CTRL, {3'h0, f_rate, 2'h1, f_slp});
    rd(BDM_ADDR_LEVEL_SEL, {5'h0, f_thr});
    apb(1'b1, BDM_ADDR_LEVEL_SEL, 32'hff, 33'h0);
    rd(BDM_ADDR_LEVEL_SEL, {5'h0, f_thr});
    check("thr", {30'h0, thr}, {30'h0, f_thr});
    rd(BDM_ADDR_WARN_LEVEL, 8'h00);
    rd(BDM_ADDR_IRQ_CTRL, 8'h00);
    rd(BDM_ADDR_IRQ_FLAG, 8'h00);
    rd(BDM_ADDR_STATUS, 8'h00);
    apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
    r = xs();
    apb(1'b1, BDM_ADDR_WARN_LEVEL, r, 33'h0);
    rd(BDM_ADDR_WARN_LEVEL, {6'h0, r[1:0]});
    check("margin", {31'h0, margin}, {31'h0, r[1:0]});
    apb(1'b1, BDM_ADDR_MODE_CTRL, {30'h0, ~f_slp}, 33'h0);
    rd(BDM_ADDR_MODE_CTRL, {3'h0, f_rate, 2'h1, f_slp});
    unlock_wr(32'h1e, 6);
    rd(BDM_ADDR_MODE_CTRL, {3'h0, f_rate, 2'h1, f_slp});
    unlock_wr(32'h1e, 0);
    rd(BDM_ADDR_MODE_CTRL, {3'h0, f_rate, 4'h6});
    // Trigger table: falling, rising and crossing, each with both supply moves
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, BDM_ADDR_IRQ_CTRL, {29'h0, 2'(i / 2), 1'b1}, 33'h0);
      repeat (2) @(posedge sys_clk);
      check("mon_en", {32'h0, mon_en}, 33'h1);
      apb(1'b1, BDM_ADDR_IRQ_FLAG, 32'h1, 33'h0);
      blw <= !i[0];
      repeat (4) @(posedge sys_clk);
      apb(1'b1, BDM_ADDR_IRQ_FLAG, 32'h0, 33'h0);
      rd(BDM_ADDR_IRQ_FLAG, {7'h0, ef[i]});
      rd(BDM_ADDR_STATUS, {7'h0, !i[0]});
      check("irq", {32'h0, irq}, {32'h0, ef[i]});
    end
    apb(1'b1, BDM_ADDR_IRQ_FLAG, 32'h1, 33'h0);
    repeat (3) @(posedge sys_clk);
    check("irq_clr", {32'h0, irq}, 33'h0);
    slp <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("sleep_en", {31'h0, det_en, det_smp}, 33'h3);
    n = 0;
    while (strobe !== 1'b1) @(posedge sys_clk);
    @(posedge sys_clk);
    while (strobe !== 1'b1) begin
      n++;
      @(posedge sys_clk);
    end
    check("strobe_gap", 33'(n + 1), f_rate ? 33'd64 : 33'd8);
    unlock_wr(32'h0, 0);
    repeat (3) @(posedge sys_clk);
    check("sleep_off", {31'h0, det_en, mon_en}, 33'h0);
    blw <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(BDM_ADDR_IRQ_FLAG, 8'h00);
    slp <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("wake", {30'h0, det_en, det_smp, hold}, 33'h4);
    // Second reset with the hold-on-wake active code in the fuses
    rstn <= 1'b0;
    f_act <= BDM_MODE_CONT_HOLD;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(BDM_ADDR_MODE_CTRL, {3'h0, f_rate, 2'h3, f_slp});
    slp <= 1'b1;
    repeat (3) @(posedge sys_clk);
    slp <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("wake_hold", {31'h0, det_en, hold}, 33'h3);
    rdy <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("hold_end", {32'h0, hold}, 33'h0);
    // Reserved trigger code never sets the flag, status still follows
    apb(1'b1, BDM_ADDR_IRQ_CTRL, 32'h7, 33'h0);
    repeat (4) @(posedge sys_clk);
    rd(BDM_ADDR_IRQ_FLAG, 8'h00);
    rd(BDM_ADDR_STATUS, 8'h01);
    repeat (3) @(posedge sys_clk);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
